// file: verilog/seb_defs.svh
/*
 * constants of the two-wire eeprom slave: register map, field bits,
 * reset values and timing counts.
 * assumes a 100 MHz hclk; included by its bare name.
 */
`ifndef SEB_DEFS_SVH
`define SEB_DEFS_SVH

`define SEB_CLK_NS 10
`define SEB_GLITCH_STD_NS 100
`define SEB_GLITCH_FAST_NS 50
`define SEB_GLITCH_STD_CYC (`SEB_GLITCH_STD_NS / `SEB_CLK_NS)
`define SEB_GLITCH_FAST_CYC (`SEB_GLITCH_FAST_NS / `SEB_CLK_NS)
`define SEB_WR_STD_MS 10
`define SEB_WR_LP_MS 15
`define SEB_WR_STD_CYC (`SEB_WR_STD_MS * 1000000 / `SEB_CLK_NS)
`define SEB_WR_LP_CYC (`SEB_WR_LP_MS * 1000000 / `SEB_CLK_NS)

`define SEB_DEV_TYPE 4'hA
`define SEB_MEM_RESET 8'hFF

`define SEB_CTRL_OFS 8'h00
`define SEB_STATUS_OFS 8'h04
`define SEB_CTRL_FAST_BIT 0
`define SEB_CTRL_LOWP_BIT 1
`define SEB_CTRL_RESET 2'h0
`define SEB_STAT_BUSY_BIT 0
`define SEB_STAT_REFUSED_BIT 1
`define SEB_STAT_WP_BIT 2
`define SEB_STAT_PIN1_BIT 3
`define SEB_STAT_PIN2_BIT 4

`endif

// file: verilog/seb_pkg.sv
/*
 * types of the two-wire eeprom slave: link states, byte phases and
 * the single state record of the core.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package seb_pkg;

    typedef enum logic [2:0] {
        SEB_ST_IDLE = 3'h0,
        SEB_ST_RX = 3'h1,
        SEB_ST_ACK = 3'h2,
        SEB_ST_TX = 3'h3,
        SEB_ST_RACK = 3'h4
    } seb_state_type;

    typedef enum logic [1:0] {
        SEB_PH_DEV = 2'h0,
        SEB_PH_WORD = 2'h1,
        SEB_PH_DATA = 2'h2
    } seb_phase_type;

    typedef struct packed {
        logic fast;
        logic lowp;
    } seb_ctrl_type;

    typedef struct packed {
        logic [4:0] s1;
        logic [4:0] s2;
        logic [1:0] lf;
        logic [1:0] lq;
        logic [3:0] c_scl;
        logic [3:0] c_sda;
        seb_state_type st;
        seb_phase_type ph;
        logic [7:0] sh;
        logic [3:0] cnt;
        logic rd;
        logic rack;
        logic oe_n;
        logic [8:0] addr;
        logic [4:0] page;
        logic [15:0] mask;
        logic [15:0][7:0] pbuf;
        logic blocked;
        logic busy;
        logic [20:0] busy_cnt;
        seb_ctrl_type ctrl;
        logic refused;
        logic aw_pend;
        logic [7:0] aw_addr;
        logic [31:0] rdata;
        logic [511:0][7:0] mem;
    } seb_core_type;

endpackage

// file: verilog/seb_eeprom_slave.sv
/*
 * two-wire serial eeprom slave, 512 bytes, with an ahb-lite port for
 * its control and status words.
 * assumes scl, sda and the strap and protect pins are asynchronous to
 * hclk and that an external pull-up makes the sda wire level.
 */
`timescale 1ns/100ps

`include "seb_defs.svh"

module seb_eeprom_slave #(
    parameter int WR_STD_CYC = `SEB_WR_STD_CYC,
    parameter int WR_LP_CYC = `SEB_WR_LP_CYC
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic chip_select_pin_one,
    input wire logic chip_select_pin_two,
    input wire logic write_protect
);

    seb_pkg::seb_core_type r;
    seb_pkg::seb_core_type n;

    always_comb begin
        logic [3:0] lim;
        logic rise;
        logic fall;
        logic start;
        logic stop;
        logic scl_f;
        logic sda_f;
        logic wp_s;
        logic [1:0] strap;
        logic ap;
        lim = 4'h0;
        rise = 1'b0;
        fall = 1'b0;
        start = 1'b0;
        stop = 1'b0;
        scl_f = 1'b0;
        sda_f = 1'b0;
        wp_s = 1'b0;
        strap = 2'h0;
        ap = 1'b0;
        n = r;

        // pins: scl, sda, protect, strap one, strap two
        n.s1 = {chip_select_pin_two, chip_select_pin_one, write_protect, sda_in, scl_in};
        n.s2 = r.s1;
        wp_s = r.s2[2];
        strap = r.s2[4:3];

        // a change must persist lim cycles before it is believed
        lim = r.ctrl.fast ? 4'(`SEB_GLITCH_FAST_CYC) : 4'(`SEB_GLITCH_STD_CYC);
        if (r.s2[0] == r.lf[0]) begin
            n.c_scl = 4'h0;
        end else if (r.c_scl + 4'h1 >= lim) begin
            n.lf[0] = r.s2[0];
            n.c_scl = 4'h0;
        end else begin
            n.c_scl = r.c_scl + 4'h1;
        end
        if (r.s2[1] == r.lf[1]) begin
            n.c_sda = 4'h0;
        end else if (r.c_sda + 4'h1 >= lim) begin
            n.lf[1] = r.s2[1];
            n.c_sda = 4'h0;
        end else begin
            n.c_sda = r.c_sda + 4'h1;
        end
        n.lq = r.lf;
        scl_f = r.lf[0];
        sda_f = r.lf[1];
        rise = scl_f & ~r.lq[0];
        fall = ~scl_f & r.lq[0];
        start = scl_f & r.lq[0] & r.lq[1] & ~sda_f;
        stop = scl_f & r.lq[0] & ~r.lq[1] & sda_f;

        // ahb: write lands in the data phase, read data is captured early
        ap = hsel & htrans[1] & hready;
        n.aw_pend = ap & hwrite;
        n.aw_addr = haddr[7:0];
        if (r.aw_pend && r.aw_addr == `SEB_CTRL_OFS) begin
            n.ctrl.fast = hwdata[`SEB_CTRL_FAST_BIT];
            n.ctrl.lowp = hwdata[`SEB_CTRL_LOWP_BIT];
        end
        if (r.aw_pend && r.aw_addr == `SEB_STATUS_OFS && hwdata[`SEB_STAT_REFUSED_BIT]) begin
            n.refused = 1'b0;
        end
        if (ap && !hwrite) begin
            n.rdata = 32'h00000000;
            if (haddr[7:0] == `SEB_CTRL_OFS) begin
                n.rdata[`SEB_CTRL_FAST_BIT] = r.ctrl.fast;
                n.rdata[`SEB_CTRL_LOWP_BIT] = r.ctrl.lowp;
            end else if (haddr[7:0] == `SEB_STATUS_OFS) begin
                n.rdata[`SEB_STAT_BUSY_BIT] = r.busy;
                n.rdata[`SEB_STAT_REFUSED_BIT] = r.refused;
                n.rdata[`SEB_STAT_WP_BIT] = wp_s;
                n.rdata[`SEB_STAT_PIN1_BIT] = strap[0];
                n.rdata[`SEB_STAT_PIN2_BIT] = strap[1];
            end
        end

        if (r.busy) begin
            // inputs are deaf until the cycle ends
            n.st = seb_pkg::SEB_ST_IDLE;
            n.oe_n = 1'b1;
            n.busy_cnt = r.busy_cnt - 21'h1;
            if (r.busy_cnt == 21'h1) begin
                n.busy = 1'b0;
            end
        end else if (start) begin
            n.st = seb_pkg::SEB_ST_RX;
            n.ph = seb_pkg::SEB_PH_DEV;
            n.cnt = 4'h0;
            n.oe_n = 1'b1;
            n.mask = 16'h0000;
            n.blocked = 1'b0;
        end else if (stop) begin
            n.st = seb_pkg::SEB_ST_IDLE;
            n.oe_n = 1'b1;
            n.mask = 16'h0000;
            if (|r.mask && !r.blocked) begin
                for (int k = 0; k < 16; k++) begin
                    if (r.mask[k]) begin
                        n.mem[{r.page, 4'(k)}] = r.pbuf[k];
                    end
                end
                n.busy = 1'b1;
                n.busy_cnt = r.ctrl.lowp ? 21'(WR_LP_CYC) : 21'(WR_STD_CYC);
            end
        end else begin
            case (r.st)
                seb_pkg::SEB_ST_RX: begin
                    if (rise) begin
                        n.sh = {r.sh[6:0], sda_f};
                        n.cnt = r.cnt + 4'h1;
                    end else if (fall && r.cnt == 4'h8) begin
                        n.st = seb_pkg::SEB_ST_ACK;
                        n.oe_n = 1'b0;
                        case (r.ph)
                            seb_pkg::SEB_PH_DEV: begin
                                if (r.sh[7:4] == `SEB_DEV_TYPE && r.sh[3:2] == strap) begin
                                    n.addr[8] = r.sh[1];
                                    n.rd = r.sh[0];
                                    n.ph = seb_pkg::SEB_PH_WORD;
                                end else begin
                                    n.st = seb_pkg::SEB_ST_IDLE;
                                    n.oe_n = 1'b1;
                                end
                            end
                            seb_pkg::SEB_PH_WORD: begin
                                n.addr[7:0] = r.sh;
                                n.page = {r.addr[8], r.sh[7:4]};
                                n.ph = seb_pkg::SEB_PH_DATA;
                            end
                            seb_pkg::SEB_PH_DATA: begin
                                if (wp_s && r.addr[8]) begin
                                    n.st = seb_pkg::SEB_ST_IDLE;
                                    n.oe_n = 1'b1;
                                    n.blocked = 1'b1;
                                    n.refused = 1'b1;
                                end else begin
                                    n.pbuf[r.addr[3:0]] = r.sh;
                                    n.mask[r.addr[3:0]] = 1'b1;
                                    n.addr[3:0] = r.addr[3:0] + 4'h1;
                                end
                            end
                            default: begin
                                n.st = seb_pkg::SEB_ST_IDLE;
                                n.oe_n = 1'b1;
                            end
                        endcase
                    end
                end
                seb_pkg::SEB_ST_ACK: begin
                    if (fall) begin
                        n.cnt = 4'h0;
                        if (r.rd) begin
                            n.st = seb_pkg::SEB_ST_TX;
                            n.sh = r.mem[r.addr];
                            n.oe_n = r.mem[r.addr][7];
                            n.addr = r.addr + 9'h001;
                        end else begin
                            n.st = seb_pkg::SEB_ST_RX;
                            n.oe_n = 1'b1;
                        end
                    end
                end
                seb_pkg::SEB_ST_TX: begin
                    if (rise) begin
                        n.cnt = r.cnt + 4'h1;
                    end else if (fall) begin
                        if (r.cnt == 4'h8) begin
                            n.st = seb_pkg::SEB_ST_RACK;
                            n.oe_n = 1'b1;
                        end else begin
                            n.sh = {r.sh[6:0], 1'b0};
                            n.oe_n = r.sh[6];
                        end
                    end
                end
                seb_pkg::SEB_ST_RACK: begin
                    if (rise) begin
                        n.rack = ~sda_f;
                    end else if (fall) begin
                        n.cnt = 4'h0;
                        if (r.rack) begin
                            n.st = seb_pkg::SEB_ST_TX;
                            n.sh = r.mem[r.addr];
                            n.oe_n = r.mem[r.addr][7];
                            n.addr = r.addr + 9'h001;
                        end else begin
                            // no ack from master: wait for its stop
                            n.st = seb_pkg::SEB_ST_IDLE;
                        end
                    end
                end
                default: begin
                    n.oe_n = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r <= '0;
            r.s1 <= 5'h03;
            r.s2 <= 5'h03;
            r.lf <= 2'h3;
            r.lq <= 2'h3;
            r.st <= seb_pkg::SEB_ST_IDLE;
            r.ph <= seb_pkg::SEB_PH_DEV;
            r.oe_n <= 1'b1;
            r.ctrl <= `SEB_CTRL_RESET;
            // array starts erased; a real part would keep its contents
            r.mem <= {512{`SEB_MEM_RESET}};
        end else begin
            r <= n;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = r.rdata;
    assign sda_out = 1'b0;
    assign sda_oe_n = r.oe_n;

endmodule

// file: bench/seb_eeprom_slave_sva.sv
/* pin checker of the two-wire slave.
   assumes a bind to the slave; scl comes from the master model. */
`timescale 1ns/100ps
module seb_eeprom_slave_sva (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_n
);
    logic [7:0] low_cnt;
    // saturates so a long low scl never wraps back into range
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            low_cnt <= 8'h00;
        end else if (scl_in) begin
            low_cnt <= 8'h00;
        end else if (low_cnt != 8'hFF) begin
            low_cnt <= low_cnt + 8'h01;
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_open_drain; sda_out == 1'b0; endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("sda driven high");
    // sooner than sync plus filter would let a glitch through
    property p_filt; $changed(sda_oe_n) |-> !scl_in && low_cnt >= 8'h05; endproperty
    a_filt: assert property (p_filt)
        else $error("sda moved too soon");
    property p_launch; $changed(sda_oe_n) |-> low_cnt <= 8'h14; endproperty
    a_launch: assert property (p_launch)
        else $error("sda moved late");
    property p_hold; scl_in && $past(scl_in) |-> $stable(sda_oe_n); endproperty
    a_hold: assert property (p_hold)
        else $error("sda moved in scl high");
    property p_ack; $fell(sda_oe_n) |=> !sda_oe_n [*8]; endproperty
    a_ack: assert property (p_ack)
        else $error("pull too short");
    property p_rel; $fell(sda_oe_n) |-> ##[1:400] $rose(sda_oe_n); endproperty
    a_rel: assert property (p_rel)
        else $error("sda not released");
    property p_start; scl_in && $fell(sda_in) |-> sda_oe_n [*8]; endproperty
    a_start: assert property (p_start)
        else $error("pull after start");
    property p_stop; scl_in && $rose(sda_in) |=> sda_oe_n throughout (scl_in [*4]); endproperty
    a_stop: assert property (p_stop)
        else $error("pull after stop");
endmodule

// file: bench/seb_m.sv
/* two-wire bus master model, open-drain pull on sda.
   assumes a pull-up on sda in the bench; scl rests high between frames. */
`timescale 1ns/100ps
module seb_m #(
    parameter int HALF = 160
) (
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // a repeated start finds scl low, so sda is released first
    task automatic start();
        sda_low = 1'b0;
        #(HALF) scl = 1'b1;
        #1300 sda_low = 1'b1;
        #(HALF) scl = 1'b0;
    endtask
    task automatic stop();
        #(HALF/2) sda_low = 1'b1;
        #(HALF/2) scl = 1'b1;
        #(HALF) sda_low = 1'b0;
    endtask
    // read late in the high phase, the slave answers well after scl falls
    task automatic bit_io(input logic b, output logic r);
        #(HALF/2) sda_low = !b;
        #(HALF/2) scl = 1'b1;
        #(HALF) r = sda;
        scl = 1'b0;
    endtask
    task automatic xfer(input logic [7:0] d, input logic ai, output logic [7:0] q,
                        output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
        bit_io(ai, ack);
    endtask
endmodule

// file: bench/tb_top.sv
/* self-checking bench of the two-wire slave and its ahb-lite words.
   assumes the slave, its checker and the master model. */
`timescale 1ns/100ps
module tb_top;
    logic hclk;
    logic hresetn;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hreadyout;
    logic [31:0] hrdata;
    logic scl;
    logic m_low;
    logic sda;
    logic sda_out;
    logic sda_oe_n;
    logic [1:0] st;
    logic wp;
    logic sg;
    logic [7:0] q;
    logic a;
    logic [31:0] r;
    logic [7:0] mdl [512];
    logic [31:0] exp_q [$];
    logic [31:0] got_q [$];
    int mismatches;
    int tests_run;
    assign sda = !(m_low || (!sda_oe_n && !sda_out));
    seb_eeprom_slave #(.WR_STD_CYC(2000), .WR_LP_CYC(3000)) seb_eeprom_slave_inst (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hresp(), .hrdata, .scl_in(scl | sg), .sda_in(sda),
        .sda_out, .sda_oe_n, .chip_select_pin_one(st[0]), .chip_select_pin_two(st[1]),
        .write_protect(wp));
    seb_m #(.HALF(160)) seb_m_inst (.scl(scl), .sda_low(m_low), .sda(sda));
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    task automatic summarize();
        $display("mismatches %0d tests_run %0d", mismatches, tests_run);
        if (mismatches == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        #1000000;
        mismatches++;
        summarize();
    end
    initial begin
        logic [31:0] e;
        logic [31:0] g;
        forever begin
            @(negedge hclk);
            while (got_q.size() > 0) begin
                e = exp_q.pop_front();
                g = got_q.pop_front();
                tests_run++;
                if (g !== e) begin
                    mismatches++;
                    $display("CHECK FAILED %0t got %h want %h", $time, g, e);
                end
            end
        end
    end
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        exp_q.push_back(e);
        got_q.push_back(g);
    endtask
    task automatic ahb(input logic [7:0] ad, input logic w, input logic [31:0] d);
        @(posedge hclk);
        haddr <= {24'h000000, ad};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic adr(input logic [1:0] s, input logic b, input logic rw, input logic e);
        seb_m_inst.start();
        seb_m_inst.xfer({4'hA, s, b, rw}, 1'b1, q, a);
        chk(32'(e), 32'(a));
    endtask
    task automatic wr(input logic b, input logic [7:0] w, input int n, input logic p);
        logic [7:0] d;
        adr(st, b, 1'b0, 1'b0);
        seb_m_inst.xfer(w, 1'b1, q, a);
        chk(32'h0, 32'(a));
        for (int i = 0; i < n; i++) begin
            d = 8'($urandom);
            seb_m_inst.xfer(d, 1'b1, q, a);
            chk(32'(p), 32'(a));
            if (!p) mdl[{b, w[7:4], 4'(w[3:0] + i)}] = d;
        end
        seb_m_inst.stop();
    endtask
    task automatic rd(input logic b, input logic [7:0] w, input int n);
        adr(st, b, 1'b0, 1'b0);
        seb_m_inst.xfer(w, 1'b1, q, a);
        adr(st, b, 1'b1, 1'b0);
        for (int i = 0; i < n; i++) begin
            seb_m_inst.xfer(8'hFF, i == n - 1, q, a);
            chk(32'(mdl[9'({b, w} + i)]), 32'(q));
        end
        seb_m_inst.stop();
    endtask
    // window edges sit well inside the count, the exact latency is unknown
    task automatic busy(input int cyc);
        adr(st, 1'b0, 1'b0, 1'b1);
        seb_m_inst.stop();
        ahb(8'h04, 1'b0, 32'h0);
        chk(32'h1, 32'(r[0]));
        repeat (cyc - 600) @(posedge hclk);
        ahb(8'h04, 1'b0, 32'h0);
        chk(32'h1, 32'(r[0]));
        repeat (700) @(posedge hclk);
        ahb(8'h04, 1'b0, 32'h0);
        chk(32'h0, 32'(r[0]));
    endtask
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        wp = 1'b0;
        sg = 1'b0;
        mismatches = 0;
        tests_run = 0;
        void'($urandom(41604));
        st = 2'($urandom);
        for (int i = 0; i < 512; i++) begin
            mdl[i] = 8'hFF;
        end
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        hsel <= 1'b1;
        repeat (30) @(posedge hclk);
        ahb(8'h00, 1'b0, 32'h0);
        chk(32'h0, r);
        // the short filter is needed for this scl rate
        ahb(8'h00, 1'b1, 32'h1);
        ahb(8'h08, 1'b1, 32'hFF);
        ahb(8'h08, 1'b0, 32'h0);
        chk(32'h0, r);
        ahb(8'h04, 1'b0, 32'h0);
        chk({27'h0, st, 3'h0}, r);
        adr(st ^ 2'h1, 1'b0, 1'b0, 1'b1);
        seb_m_inst.stop();
        wr(1'b0, 8'h0E, 3, 1'b0);
        busy(2000);
        rd(1'b0, 8'h0E, 3);
        rd(1'b0, 8'h00, 1);
        wr(1'b1, 8'h20, 17, 1'b0);
        busy(2000);
        rd(1'b1, 8'h1F, 18);
        rd(1'b0, 8'h20, 1);
        // 30 ns scl spike while the slave drives bit 7: an extra edge would shift the byte
        adr(st, 1'b0, 1'b0, 1'b0);
        seb_m_inst.xfer(8'h0E, 1'b1, q, a);
        adr(st, 1'b0, 1'b1, 1'b0);
        repeat (20) @(posedge hclk);
        sg <= 1'b1;
        repeat (3) @(posedge hclk);
        sg <= 1'b0;
        seb_m_inst.xfer(8'hFF, 1'b1, q, a);
        chk(32'(mdl[9'h00E]), 32'(q));
        seb_m_inst.stop();
        @(posedge hclk);
        wp <= 1'b1;
        wr(1'b1, 8'h40, 1, 1'b1);
        adr(st, 1'b1, 1'b0, 1'b0);
        seb_m_inst.stop();
        rd(1'b1, 8'h40, 1);
        ahb(8'h04, 1'b0, 32'h0);
        chk({27'h0, st, 3'h6}, r);
        ahb(8'h04, 1'b1, 32'h2);
        ahb(8'h04, 1'b0, 32'h0);
        chk({27'h0, st, 3'h4}, r);
        ahb(8'h00, 1'b1, 32'h3);
        wr(1'b0, 8'h50, 2, 1'b0);
        busy(3000);
        rd(1'b0, 8'h50, 2);
        repeat (20) @(posedge hclk);
        summarize();
    end
endmodule
bind seb_eeprom_slave seb_eeprom_slave_sva seb_eeprom_slave_sva_inst (
    .hclk, .hresetn, .scl_in, .sda_in, .sda_out, .sda_oe_n);
